// >>> design/tmc_pkg.sv
// ==========================================================
// timer modulator counter constants
package tmc_pkg;
  // register byte offsets on the axi4-lite port
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CLKSEL = 8'h08;
  localparam logic [7:0] ADDR_CMODE1 = 8'h0C;
  localparam logic [7:0] ADDR_CMODE2 = 8'h10;
  localparam logic [7:0] ADDR_CMP1 = 8'h14;
  localparam logic [7:0] ADDR_CMP2 = 8'h18;
  localparam logic [7:0] ADDR_CAPT = 8'h1C;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  // values after reset
  localparam logic [3:0] MODE_RST = 4'hF;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [7:0] CLKSEL_RST = 8'h02;
  localparam logic [3:0] CMODE_RST = 4'h0;
  localparam logic [7:0] CMP_RST = 8'hFF;
  // run control register fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_INIT = 1;
  localparam int CTRL_TRIG = 2;
  localparam int CTRL_EIM = 3;
  // compare-mode register fields
  localparam int CM_RST = 0;
  localparam int CM_IRQ = 1;
  localparam int CM_TOG = 2;
  localparam int CM_SGL = 3;
  // clock-select register fields
  localparam int CS_EXT = 0;
  localparam int CS_EDGE = 1;
  localparam int CS_DIV = 4;
  // status register fields
  localparam int ST_RUN = 0;
  localparam int ST_CM1 = 1;
  localparam int ST_CM2 = 2;
  localparam int ST_EDGE = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // mode codes
  typedef enum logic [3:0] {
    TMC_M1 = 4'b1111, TMC_M2 = 4'b1110, TMC_M3 = 4'b1101, TMC_M4 = 4'b1100,
    TMC_M5 = 4'b1011, TMC_M6 = 4'b1010, TMC_M7 = 4'b1001, TMC_M8 = 4'b1000,
    TMC_M9 = 4'b0111, TMC_M10 = 4'b0110, TMC_M11 = 4'b0101, TMC_M12 = 4'b0100
  } tmc_mode_t;
  // run sequencer states
  typedef enum logic [1:0] {
    TMC_IDLE = 2'b00, TMC_WAIT = 2'b01, TMC_CNT = 2'b10
  } tmc_state_t;
endpackage : tmc_pkg

// >>> design/tmc_timer.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - 8-bit up counter, two compares, one capture
// - external input synchronised to system clock
// - trigger mode waits for input edge
// - single-action match fires once per start
// - match resets, interrupts or toggles per mask
// - compares alternate one, two, one after start
// - one single-action register: only other afterwards
// - run register: start, initial level, edge mask
// - clock select: source and active edge
// - edge interrupt only when masked in, stopped
// - status shows run, matches, edge
// - match after programmed value plus one counts
// - mode 1 counts, capture shows count
// - mode 2 first edge starts, later capture-restart
// - trigger restart re-arms single actions
// - mode 3 companion toggle captures, resets, re-arms
// - modes 4, 5 drive companion output
// - mode 6 companion toggle gates carrier
// - mode 7 serial output gates carrier
// - mode 8 serial output picks compare register
// - mode 9 serial picks width, companion restarts
// - four-bit mode code, lowest four forbidden
module tmc_timer
  import tmc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_timer_input,
  input wire logic companion_toggle_flop,
  input wire logic companion_output,
  input wire logic serial_data_out,
  input wire logic companion_restart,
  output logic timer_output_pin,
  output logic timer_irq
);
  // ==========================================================
  // state
  logic [3:0] mode_ff; // mode_select_register
  logic [3:0] ctrl_ff; // run_control_register
  logic [7:0] clksel_ff; // source, edge, prescale
  logic [3:0] cmode1_ff; // compare_mode_reg_one
  logic [3:0] cmode2_ff; // compare_mode_reg_two
  logic [7:0] cmp1_ff; // compare_value_one
  logic [7:0] cmp2_ff; // compare_value_two
  logic [7:0] capt_ff; // capture register
  logic [3:0] stat_ff; // sticky event flags, bit 0 unused
  logic [7:0] cnt_ff; // the counter
  logic sel2_ff; // next compare is register two
  logic done1_ff; // single action one used up
  logic done2_ff; // single action two used up
  logic tog_ff; // own_toggle_flop
  logic out_ff; // registered output pin
  logic [2:0] div_ff; // internal prescaler
  logic ext_s1_ff, ext_s2_ff, ext_s3_ff; // input synchroniser
  logic ctog_d_ff; // last companion toggle level
  tmc_state_t state_ff; // run sequencer
  tmc_state_t nxt_state;
  // bus holding registers
  logic aw_hold_ff, w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic wstrb0_ff;

  // ==========================================================
  // input stage
  // two flops before use; third stage only for edge finding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_s3_ff <= 1'b0;
      ctog_d_ff <= 1'b0;
    end else begin
      ext_s1_ff <= external_timer_input;
      ext_s2_ff <= ext_s1_ff;
      ext_s3_ff <= ext_s2_ff;
      ctog_d_ff <= companion_toggle_flop;
    end
  end

  logic rise, fall, act_edge, companion_toggle_flop_chg;
  assign rise = ext_s2_ff & ~ext_s3_ff;
  assign fall = ~ext_s2_ff & ext_s3_ff;
  // edge code: bit0 rising, bit1 falling, both for any edge
  assign act_edge = (clksel_ff[CS_EDGE] & rise) | (clksel_ff[CS_EDGE+1] & fall);
  assign companion_toggle_flop_chg = companion_toggle_flop ^ ctog_d_ff;

  // ==========================================================
  // mode decode
  logic is_m2, is_m3, is_sel_so, bad_mode, running, int_only;
  assign is_m2 = (mode_ff == TMC_M2) || (mode_ff == TMC_M5);
  assign is_m3 = (mode_ff == TMC_M3);
  assign is_sel_so = (mode_ff == TMC_M8) || (mode_ff == TMC_M9);
  assign bad_mode = (mode_ff[3:2] == 2'b00);
  // forbidden codes keep the counter idle rather than guess
  assign running = (state_ff == TMC_CNT) && !bad_mode;
  assign int_only = is_m2; // trigger-restart modes count internally

  // ==========================================================
  // clock source: prescaled system clock or input edges
  logic int_tick, tick;
  assign int_tick = (div_ff == clksel_ff[CS_DIV +: 3]);
  assign tick = (clksel_ff[CS_EXT] && !int_only) ? act_edge : int_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= 3'h0;
    end else if (int_tick) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  // ==========================================================
  // run sequencer
  logic start_evt, restart_evt;
  assign start_evt = (state_ff != TMC_CNT) && (nxt_state == TMC_CNT);
  // restart events reset the counter and re-arm single actions
  assign restart_evt = running && ((is_m2 && act_edge)
    || (is_m3 && companion_toggle_flop_chg)
    || ((mode_ff == TMC_M9) && companion_restart));

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      TMC_IDLE: begin
        if (ctrl_ff[CTRL_RUN]) begin
          // mode 2 and trigger mode wait for the input
          nxt_state = (ctrl_ff[CTRL_TRIG] || is_m2) ? TMC_WAIT : TMC_CNT;
        end
      end
      TMC_WAIT: begin
        if (!ctrl_ff[CTRL_RUN]) begin
          nxt_state = TMC_IDLE;
        end else if (act_edge) begin
          nxt_state = TMC_CNT;
        end
      end
      TMC_CNT: begin
        if (!ctrl_ff[CTRL_RUN]) begin
          nxt_state = TMC_IDLE;
        end
      end
      default: begin
        nxt_state = TMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= TMC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // compare stage
  logic sel_eff, cur_done, oth_done, hit, match1, match2;
  logic [7:0] cmp_val;
  logic [3:0] cm_cur;
  // modes 8 and 9 take the register from the serial data
  assign sel_eff = is_sel_so ? serial_data_out : sel2_ff;
  assign cmp_val = sel_eff ? cmp2_ff : cmp1_ff;
  assign cm_cur = sel_eff ? cmode2_ff : cmode1_ff;
  assign cur_done = sel_eff ? done2_ff : done1_ff;
  assign oth_done = sel_eff ? done1_ff : done2_ff;
  // reaching x from zero takes x+1 ticks, the tick at x included
  assign hit = running && tick && (cnt_ff == cmp_val) && !cur_done;
  assign match1 = hit && !sel_eff;
  assign match2 = hit && sel_eff;

  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 8'h00;
    end else if (start_evt || restart_evt) begin
      cnt_ff <= 8'h00;
    end else if (hit && cm_cur[CM_RST]) begin
      cnt_ff <= 8'h00;
    end else if (running && tick) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // compare alternation; a used-up single action is skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel2_ff <= 1'b0;
    end else if (start_evt || restart_evt) begin
      sel2_ff <= 1'b0;
    end else if (hit && !oth_done) begin
      sel2_ff <= ~sel_eff;
    end
  end

  // single-action bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done1_ff <= 1'b0;
      done2_ff <= 1'b0;
    end else if (start_evt || restart_evt) begin
      done1_ff <= 1'b0;
      done2_ff <= 1'b0;
    end else begin
      if (match1 && cmode1_ff[CM_SGL]) begin
        done1_ff <= 1'b1;
      end
      if (match2 && cmode2_ff[CM_SGL]) begin
        done2_ff <= 1'b1;
      end
    end
  end

  // capture: on restart events except in mode 9, else tracks the count in mode 1/4
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capt_ff <= 8'h00;
    end else if (restart_evt && !(mode_ff == TMC_M9)) begin
      capt_ff <= cnt_ff;
    end else if (mode_ff == TMC_M1 || mode_ff == TMC_M4) begin
      capt_ff <= cnt_ff;
    end
  end

  // ==========================================================
  // output stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_ff <= 1'b0;
    end else if (state_ff != TMC_CNT) begin
      tog_ff <= ctrl_ff[CTRL_INIT];
    end else if (hit && cm_cur[CM_TOG]) begin
      tog_ff <= ~tog_ff;
    end
  end

  logic nxt_out;
  always_comb begin
    case (mode_ff)
      TMC_M4, TMC_M5: nxt_out = companion_output;
      TMC_M6: nxt_out = tog_ff & companion_toggle_flop;
      TMC_M7: nxt_out = tog_ff & serial_data_out;
      default: nxt_out = tog_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end
  assign timer_output_pin = out_ff;

  // ==========================================================
  // axi4-lite write channel
  logic do_wr, wr_en, bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_map;
  assign awready = !aw_hold_ff && !bvalid_ff;
  assign wready = !w_hold_ff && !bvalid_ff;
  assign do_wr = aw_hold_ff && w_hold_ff;
  // fields all live in byte lane 0
  assign wr_en = do_wr && wstrb0_ff;
  assign wr_map = (awaddr_ff <= ADDR_STAT) && (awaddr_ff[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb0_ff <= wstrb[0];
      end
      if (do_wr) begin
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MODE_RST;
      ctrl_ff <= CTRL_RST;
      clksel_ff <= CLKSEL_RST;
      cmode1_ff <= CMODE_RST;
      cmode2_ff <= CMODE_RST;
      cmp1_ff <= CMP_RST;
      cmp2_ff <= CMP_RST;
    end else if (wr_en) begin
      case (awaddr_ff)
        ADDR_MODE: mode_ff <= wdata_ff[3:0];
        ADDR_CTRL: ctrl_ff <= wdata_ff[3:0];
        ADDR_CLKSEL: clksel_ff <= wdata_ff[7:0];
        ADDR_CMODE1: cmode1_ff <= wdata_ff[3:0];
        ADDR_CMODE2: cmode2_ff <= wdata_ff[3:0];
        ADDR_CMP1: cmp1_ff <= wdata_ff[7:0];
        ADDR_CMP2: cmp2_ff <= wdata_ff[7:0];
        default: begin
        end
      endcase
    end
  end

  // sticky event flags: write one to clear, a new event wins
  logic [3:0] set_v, clr_v;
  assign set_v = {act_edge && ctrl_ff[CTRL_EIM] && !ctrl_ff[CTRL_RUN],
    match2 && cmode2_ff[CM_IRQ], match1 && cmode1_ff[CM_IRQ], 1'b0};
  assign clr_v = (wr_en && awaddr_ff == ADDR_STAT) ? wdata_ff[3:0] : 4'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= 4'h0;
    end else begin
      stat_ff <= (stat_ff & ~clr_v) | set_v;
    end
  end
  // all events share one line
  assign timer_irq = |stat_ff[3:1];

  // ==========================================================
  // axi4-lite read channel
  logic rvalid_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  assign arready = !rvalid_ff;

  always_comb begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = RESP_OKAY;
    case (araddr)
      ADDR_MODE: nxt_rdata[3:0] = mode_ff;
      ADDR_CTRL: nxt_rdata[3:0] = ctrl_ff;
      ADDR_CLKSEL: nxt_rdata[7:0] = clksel_ff;
      ADDR_CMODE1: nxt_rdata[3:0] = cmode1_ff;
      ADDR_CMODE2: nxt_rdata[3:0] = cmode2_ff;
      ADDR_CMP1: nxt_rdata[7:0] = cmp1_ff;
      ADDR_CMP2: nxt_rdata[7:0] = cmp2_ff;
      ADDR_CAPT: nxt_rdata[7:0] = capt_ff;
      ADDR_STAT: nxt_rdata[3:0] = {stat_ff[3:1], running};
      default: nxt_rresp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cnt_inc;
    running && tick && !hit && !restart_evt && !start_evt && ctrl_ff[CTRL_RUN]
      |=> cnt_ff == $past(cnt_ff) + 8'h01;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

  property p_sync;
    $rose(ext_s2_ff) |-> $past(external_timer_input, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input not delayed two flops");

  property p_trig_hold;
    state_ff == TMC_WAIT && !act_edge |=> cnt_ff == $past(cnt_ff);
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("counted before trigger");

  // a single-action match must use itself up at once
  property p_single;
    match1 && cmode1_ff[CM_SGL] && !restart_evt |=> done1_ff && !match1;
  endproperty
  a_single: assert property (p_single) else $error("single action repeated");

  property p_cm_reset;
    hit && cm_cur[CM_RST] |=> cnt_ff == 8'h00;
  endproperty
  a_cm_reset: assert property (p_cm_reset) else $error("match did not reset");

  property p_alt;
    match1 && !done2_ff && !is_sel_so && !restart_evt && !start_evt |=> sel2_ff;
  endproperty
  a_alt: assert property (p_alt) else $error("compare did not alternate");

  property p_edge_irq;
    act_edge && ctrl_ff[CTRL_EIM] && !ctrl_ff[CTRL_RUN] |=> stat_ff[ST_EDGE] ##0 timer_irq;
  endproperty
  a_edge_irq: assert property (p_edge_irq) else $error("edge flag missing");

  property p_capt;
    restart_evt && is_m2 |=> capt_ff == $past(cnt_ff) && cnt_ff == 8'h00;
  endproperty
  a_capt: assert property (p_capt) else $error("capture restart wrong");

  property p_out_m4;
    mode_ff == TMC_M4 |=> timer_output_pin == $past(companion_output);
  endproperty
  a_out_m4: assert property (p_out_m4) else $error("companion output not routed");

  c_match2: cover property (match2);
  c_restart: cover property (restart_evt ##1 match1);
  c_edge_irq: cover property (stat_ff[ST_EDGE]);
endmodule : tmc_timer
`default_nettype wire

// >>> dv/tmc_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// companion timer and serial unit stand-in
module tmc_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en, // let the companion toggle run
  input wire logic lvl, // idle level of toggle flop and serial data
  input wire logic [7:0] half, // cycles per toggle half period
  output logic companion_toggle_flop,
  output logic companion_output,
  output logic serial_data_out,
  output logic companion_restart
);
  logic [7:0] cnt_ff; // cycles since the last toggle
  // toggle every half cycles, restart pulse with each toggle
  always_ff @(posedge aclk) begin
    if (!aresetn || !en) begin
      cnt_ff <= 8'h00;
      companion_toggle_flop <= lvl;
      companion_restart <= 1'b0;
    end else if (cnt_ff == half - 8'h01) begin
      cnt_ff <= 8'h00;
      companion_toggle_flop <= ~companion_toggle_flop;
      companion_restart <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      companion_restart <= 1'b0;
    end
  end
  // serial data held at the idle level, one flop late like a shifter
  always_ff @(posedge aclk) begin
    serial_data_out <= lvl;
  end
  assign companion_output = companion_toggle_flop;
endmodule : tmc_partner
`default_nettype wire

// >>> dv/tmc_timer_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// self-checking bench
module tmc_timer_bench import tmc_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rdv;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin, irq;
  logic [1:0] bresp, rresp, bres, rres;
  logic ext_in = 1'b0, en = 1'b0, lvl = 1'b0;
  logic [7:0] half = 8'h0A;
  logic ctf, cout, sdo, crst;
  int failures = 0;
  int n_checks = 0;

  // 100 ns period
  always #50 aclk = ~aclk;

  tmc_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_timer_input(ext_in), .companion_toggle_flop(ctf),
    .companion_output(cout), .serial_data_out(sdo),
    .companion_restart(crst), .timer_output_pin(pin), .timer_irq(irq));

  tmc_partner u_far (.aclk(aclk), .aresetn(aresetn), .en(en), .lvl(lvl),
    .half(half), .companion_toggle_flop(ctf), .companion_output(cout),
    .serial_data_out(sdo), .companion_restart(crst));

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t %s seen %h want %h", $time, m, s, e);
    end
  endtask : chk

  // ==========================================================
  // axi4-lite master; waits only on the handshakes
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bres = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rdv = rdata;
    rres = rresp;
    rready <= 1'b0;
  endtask : rd

  // stop, program, clear flags, then write the run control value
  task automatic cfg(input logic [3:0] m, input logic [3:0] c1m, input logic [3:0] c2m,
      input logic [7:0] v1, input logic [7:0] v2, input logic [3:0] ct);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_MODE, 32'(m));
    wr(ADDR_CMODE1, 32'(c1m));
    wr(ADDR_CMODE2, 32'(c2m));
    wr(ADDR_CMP1, 32'(v1));
    wr(ADDR_CMP2, 32'(v2));
    wr(ADDR_STAT, 32'hE);
    wr(ADDR_CTRL, 32'(ct));
  endtask : cfg

  // cycles until the output pin changes; 200 means it stood still
  task automatic hp(output logic [31:0] n);
    logic p;
    p = pin;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (pin === p && n < 200);
  endtask : hp

  // rising input edges exactly n cycles apart when called back to back
  task automatic pulse(input int n);
    @(posedge aclk);
    ext_in <= 1'b1;
    repeat (2) @(posedge aclk);
    ext_in <= 1'b0;
    repeat (n - 3) @(posedge aclk);
  endtask : pulse

  // ==========================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] ad [9] = '{ADDR_MODE, ADDR_CTRL, ADDR_CLKSEL, ADDR_CMODE1,
      ADDR_CMODE2, ADDR_CMP1, ADDR_CMP2, ADDR_CAPT, ADDR_STAT};
    logic [7:0] ex [9] = '{8'h0F, 8'h00, 8'h02, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rd(ad[i]);
      chk(rdv, 32'(ex[i]), "reset value");
    end
    wr(ADDR_CAPT, 32'h55);
    rd(ADDR_CAPT);
    chk(rdv, 32'h0, "capture read only");
    wr(8'h40, 32'h1);
    chk(32'(bres), 32'(RESP_SLVERR), "unmapped write");
    rd(8'h40);
    chk(32'(rres), 32'(RESP_SLVERR), "unmapped read");
    chk(rdv, 32'h0, "unmapped data");
  endtask : t_regs

  // pin level before start follows the init bit
  task automatic t_init;
    cfg(TMC_M1, 4'h0, 4'h0, 8'hFF, 8'hFF, 4'h2);
    repeat (3) @(posedge aclk);
    chk(32'(pin), 32'h1, "init high");
    wr(ADDR_CTRL, 32'h0);
    repeat (3) @(posedge aclk);
    chk(32'(pin), 32'h0, "init low");
  endtask : t_init

  // toggle+reset on both: half periods 2 and 6 alternate
  task automatic t_alt;
    logic [31:0] a, b;
    cfg(TMC_M1, 4'h7, 4'h7, 8'h01, 8'h05, 4'h1);
    hp(a);
    hp(a);
    hp(b);
    chk(a + b, 32'd8, "alternate sum");
    chk(32'(a == 2 || a == 6), 32'h1, "alternate value");
    rd(ADDR_STAT);
    chk(rdv & 32'h7, 32'h7, "run and match flags");
    chk(32'(irq), 32'h1, "match irq");
  endtask : t_alt

  // single action on compare 1: after it only compare 2 counts
  task automatic t_single;
    logic [31:0] a, b;
    cfg(TMC_M1, 4'hF, 4'h7, 8'h01, 8'h05, 4'h1);
    repeat (20) @(posedge aclk);
    wr(ADDR_STAT, 32'hE);
    hp(a);
    hp(a);
    hp(b);
    chk(a, 32'd6, "single first");
    chk(b, 32'd6, "single second");
    rd(ADDR_STAT);
    chk(rdv & 32'h6, 32'h4, "only match two");
  endtask : t_single

  // serial level picks the compare register
  task automatic t_fsk;
    logic [31:0] a;
    cfg(TMC_M8, 4'h5, 4'h5, 8'h01, 8'h05, 4'h1);
    for (int i = 0; i < 2; i++) begin
      lvl <= i[0];
      hp(a);
      hp(a);
      hp(a);
      chk(a, i ? 32'd6 : 32'd2, "fsk half period");
    end
    lvl <= 1'b0;
  endtask : t_fsk

  // burst modes: carrier passes only while the gate is high
  task automatic t_gate;
    logic [31:0] a;
    logic [3:0] md [2] = '{TMC_M6, TMC_M7};
    for (int i = 0; i < 2; i++) begin
      lvl <= 1'b0;
      cfg(md[i], 4'h5, 4'h5, 8'h01, 8'h01, 4'h1);
      hp(a);
      hp(a);
      chk(a, 32'd200, "gated off still");
      chk(32'(pin), 32'h0, "gated off low");
      lvl <= 1'b1;
      hp(a);
      hp(a);
      chk(a, 32'd2, "carrier half period");
    end
    lvl <= 1'b0;
  endtask : t_gate

  // modes 4 and 5 drive the companion output on the pin
  task automatic t_route;
    logic [31:0] a;
    logic [3:0] md [2] = '{TMC_M4, TMC_M5};
    for (int i = 0; i < 2; i++) begin
      cfg(md[i], 4'h0, 4'h0, 8'hFF, 8'hFF, 4'h1);
      half <= 8'h0A;
      en <= 1'b1;
      hp(a);
      hp(a);
      chk(a, 32'd10, "companion on pin");
      en <= 1'b0;
    end
  endtask : t_route

  // capture spacing tracks trigger spacing exactly
  task automatic t_cap2;
    logic [31:0] c1;
    cfg(TMC_M2, 4'hA, 4'h0, 8'h05, 8'hFF, 4'h1);
    pulse(20);
    pulse(20);
    pulse(20);
    rd(ADDR_CAPT);
    c1 = rdv;
    pulse(40);
    pulse(40);
    rd(ADDR_CAPT);
    chk(rdv - c1, 32'd20, "edge capture");
    // the single match is used up; only a new trigger brings it back
    wr(ADDR_STAT, 32'hE);
    pulse(40);
    rd(ADDR_STAT);
    chk(rdv & 32'h2, 32'h2, "single re-armed");
  endtask : t_cap2

  task automatic t_cap3;
    logic [31:0] c1;
    cfg(TMC_M3, 4'h0, 4'h0, 8'hFF, 8'hFF, 4'h1);
    half <= 8'd15;
    en <= 1'b1;
    repeat (70) @(posedge aclk);
    rd(ADDR_CAPT);
    c1 = rdv;
    half <= 8'd35;
    repeat (150) @(posedge aclk);
    rd(ADDR_CAPT);
    chk(rdv - c1, 32'd20, "toggle capture");
    en <= 1'b0;
  endtask : t_cap3

  // mode 9: companion restarts re-arm, serial level picks the register
  task automatic t_pwm;
    logic [31:0] a;
    lvl <= 1'b0;
    half <= 8'h0A;
    cfg(TMC_M9, 4'hC, 4'h0, 8'h03, 8'h03, 4'h1);
    en <= 1'b1;
    hp(a);
    hp(a);
    hp(a);
    chk(a, 32'd10, "restart width");
    // register two has no toggle action, so the pin must stand
    lvl <= 1'b1;
    hp(a);
    chk(a, 32'd200, "serial picks two");
    en <= 1'b0;
    lvl <= 1'b0;
  endtask : t_pwm

  // edge flag only while stopped with the mask set
  task automatic t_edge;
    cfg(TMC_M1, 4'h0, 4'h0, 8'hFF, 8'hFF, 4'h8);
    pulse(8);
    chk(32'(irq), 32'h1, "edge irq");
    rd(ADDR_STAT);
    chk(rdv & 32'h8, 32'h8, "edge flag");
    wr(ADDR_STAT, 32'h8);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0, "edge cleared");
    wr(ADDR_CTRL, 32'h9);
    pulse(8);
    rd(ADDR_STAT);
    chk(rdv & 32'h8, 32'h0, "no flag while run");
  endtask : t_edge

  // trigger bit holds the count until an input edge
  task automatic t_trig;
    logic [31:0] c1;
    cfg(TMC_M1, 4'h0, 4'h0, 8'hFF, 8'hFF, 4'h5);
    rd(ADDR_CAPT);
    c1 = rdv;
    repeat (20) @(posedge aclk);
    rd(ADDR_CAPT);
    chk(rdv, c1, "held before edge");
    pulse(20);
    rd(ADDR_CAPT);
    // edge seen 3 cycles after the pin, count from zero, capture one behind
    chk(rdv, 32'd16, "counting after edge");
    wr(ADDR_MODE, 32'h3);
    rd(ADDR_STAT);
    chk(rdv & 32'h1, 32'h0, "forbidden mode idle");
  endtask : t_trig

  task automatic end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // main sequence; watchdog cuts a hang well past the expected run
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_init();
    t_alt();
    t_single();
    t_fsk();
    t_gate();
    t_route();
    t_cap2();
    t_cap3();
    t_pwm();
    t_edge();
    t_trig();
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    end_of_test();
  end
endmodule : tmc_timer_bench
`default_nettype wire
